/* hdl/rsc_pkg.sv */
// Shared constants, register layouts and carrier types of the RDS status and audio control block
package rsc_pkg;

    localparam int unsigned RSC_CLK_HZ        = 50_000_000;
    localparam int unsigned RSC_MS_PER_S      = 1000;
    localparam int unsigned RSC_READY_HOLD_MS = 40;
    localparam int unsigned RSC_IRQ_LOW_MS    = 5;
    localparam int unsigned RSC_READY_HOLD_CYC =
        (RSC_CLK_HZ / RSC_MS_PER_S) * RSC_READY_HOLD_MS;
    localparam int unsigned RSC_IRQ_LOW_CYC =
        (RSC_CLK_HZ / RSC_MS_PER_S) * RSC_IRQ_LOW_MS;

    localparam int RSC_TMR_W  = 22;
    localparam int RSC_ADDR_W = 4;
    localparam int RSC_DATA_W = 16;
    localparam int RSC_BLOCKS = 4;

    localparam logic [RSC_ADDR_W-1:0] RSC_REG_CTRL   = 4'h2;
    localparam logic [RSC_ADDR_W-1:0] RSC_REG_CFG    = 4'h4;
    localparam logic [RSC_ADDR_W-1:0] RSC_REG_AUDIO  = 4'h5;
    localparam logic [RSC_ADDR_W-1:0] RSC_REG_STATUS = 4'ha;
    localparam logic [RSC_ADDR_W-1:0] RSC_REG_BLKERR = 4'hb;

    // Bit error count thresholds of the error level encoding
    localparam logic [2:0] RSC_ERR_LOW_MAX = 3'h2;
    localparam logic [2:0] RSC_ERR_MID_MAX = 3'h5;

    typedef enum logic [1:0] {
        RSC_LVL_NONE = 2'h0,
        RSC_LVL_LOW  = 2'h1,
        RSC_LVL_MID  = 2'h2,
        RSC_LVL_BAD  = 2'h3
    } rsc_err_lvl_t;

    typedef enum logic [1:0] {
        RSC_PIN_HIZ     = 2'h0,
        RSC_PIN_SPECIAL = 2'h1,
        RSC_PIN_LOW     = 2'h2,
        RSC_PIN_HIGH    = 2'h3
    } rsc_pin_fn_t;

    typedef struct packed {
        logic       audio_silence;
        logic       soft_silence_off;
        logic       force_single_channel;
        logic [5:0] rsv1;
        logic       rds_verbose_select;
        logic [5:0] rsv0;
    } rsc_ctrl_reg_t;

    typedef struct packed {
        logic        rds_irq_enable;
        logic [1:0]  rsv2;
        logic        rds_enable;
        logic        emphasis_time_select;
        logic        gain_loop_off;
        logic [1:0]  blend_range_adjust;
        logic [1:0]  rsv1;
        rsc_pin_fn_t pin_three_function;
        rsc_pin_fn_t pin_two_function;
        rsc_pin_fn_t pin_one_function;
    } rsc_cfg_reg_t;

    typedef struct packed {
        logic [1:0] soft_silence_rate;
        logic [1:0] soft_silence_depth;
        logic [2:0] rsv1;
        logic       volume_range_extend;
        logic [3:0] rsv0;
        logic [3:0] volume;
    } rsc_audio_reg_t;

    typedef struct packed {
        logic       rds_group_ready;
        logic [1:0] rsv2;
        logic       rds_sync_flag;
        logic [2:0] rsv1;
        logic       pilot_lock_flag;
        logic [1:0] block_a_error_level;
        logic [1:0] bus_mode_strap;
        logic       rsv0;
        logic [2:0] pin_level;
    } rsc_status_reg_t;

    typedef struct packed {
        logic [1:0] block_b_error_level;
        logic [1:0] block_c_error_level;
        logic [1:0] block_d_error_level;
        logic [9:0] rsv0;
    } rsc_blkerr_reg_t;

    // From the RDS decoder: one-cycle group strobe with its qualifiers
    typedef struct packed {
        logic                      group_strobe;
        logic                      group_valid;
        logic                      sync;
        logic [RSC_BLOCKS-1:0][2:0] err_cnt;
    } rsc_rds_in_t;

    typedef struct packed {
        logic       gain_loop_off;
        logic       force_single_channel;
        logic [1:0] blend_range_adjust;
        logic       emphasis_time_select;
        logic       audio_silence;
        logic [3:0] volume;
        logic       volume_range_extend;
        logic [1:0] soft_silence_rate;
        logic [1:0] soft_silence_depth;
        logic       soft_silence_off;
    } rsc_audio_ctl_t;

    typedef struct packed {
        logic [RSC_TMR_W-1:0] remain;
    } rsc_tmr_state_t;

    typedef struct packed {
        rsc_ctrl_reg_t                     ctrl;
        rsc_cfg_reg_t                      cfg;
        rsc_audio_reg_t                    audio;
        logic                              sync_flag;
        logic                              pilot_lock;
        logic [RSC_BLOCKS-1:0][1:0]        levels;
        logic [1:0]                        strap;
        logic                              strap_pending;
        logic [RSC_DATA_W-1:0]             rdata;
        logic [2:0]                        pin_out;
        logic [2:0]                        pin_oe;
    } rsc_state_t;

endpackage

/* hdl/rsc_hold_timer.sv */
// Retriggerable hold timer: active for CYCLES cycles after each start
`timescale 1ns/1ps
module rsc_hold_timer
    import rsc_pkg::*;
#(
    parameter logic [RSC_TMR_W-1:0] CYCLES = RSC_TMR_W'(RSC_IRQ_LOW_CYC)
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic start,
    output logic      active
);

    rsc_tmr_state_t state;
    rsc_tmr_state_t next_state;

    always_comb begin
        next_state = state;
        if (start) begin
            next_state.remain = CYCLES;
        end else if (state.remain != '0) begin
            next_state.remain = state.remain - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign active = (state.remain != '0);

endmodule

/* hdl/rsc_rds_ctrl.sv */
// RDS reporting, general pin and audio control registers of the FM tuner core
//
// Notes on behaviour
// - RDS reporting happens only while rds_enable is set.
// - rds_verbose_select low, its reset value, selects standard reporting.
// - Standard mode: each valid group holds rds_group_ready for at least 40 ms.
// - Standard mode: irq enabled, pin two function 01, pin two low 5 ms per group.
// - Standard mode: invalid groups raise neither ready nor a pin pulse.
// - Standard mode: sync flag and all error levels read as zero.
// - rds_verbose_select high selects verbose reporting with sync and error levels.
// - Verbose mode: sync flag follows decoder block synchronisation.
// - Verbose mode: any group while synchronised holds ready for 40 ms.
// - Verbose mode: with irq enabled and pin two function 01, any group while synchronised pulses pin two low 5 ms.
// - Error level code: 0 none, 1 one-two, 2 three-five, 3 six or more.
// - Pins one and three levels at reset exit select 2-wire or 3-wire bus.
// - General pins configured by register 04h bits 5:0, with special functions on pins two and three.
// - General pins work regardless of enable bits and receive power state.
// - gain_loop_off disables the automatic gain loop.
// - pilot_lock_flag reports stereo; force_single_channel forces mono output.
// - blend_range_adjust selects the stereo to mono blend range.
// - emphasis_time_select picks 50 or 75 us de-emphasis.
// - audio_silence mutes the audio outputs.
// - Four-bit volume; volume_range_extend widens range from -28 to -58 dBFS.
// - soft_silence_rate sets attack/decay, 00 fastest; depth 00 deepest.
// - soft_silence_off disables soft mute entirely.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rsc_rds_ctrl
    import rsc_pkg::*;
#(
    parameter logic [RSC_TMR_W-1:0] READY_HOLD_CYCLES = RSC_TMR_W'(RSC_READY_HOLD_CYC),
    parameter logic [RSC_TMR_W-1:0] IRQ_LOW_CYCLES    = RSC_TMR_W'(RSC_IRQ_LOW_CYC)
) (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic [RSC_ADDR_W-1:0] address,
    input  wire logic [RSC_DATA_W-1:0] write_data,
    input  wire logic                  write_strobe,
    input  wire logic                  read_strobe,
    output logic [RSC_DATA_W-1:0]      read_data,
    input  wire rsc_rds_in_t           rds_in,
    input  wire logic                  pilot_detect,
    output logic                       rds_enable,
    output logic                       rds_group_ready,
    output rsc_audio_ctl_t             audio_ctl,
    output logic [1:0]                 bus_mode_strap,
    input  wire logic                  general_pin_one_in,
    output logic                       general_pin_one_out,
    output logic                       general_pin_one_oe,
    input  wire logic                  general_pin_two_in,
    output logic                       general_pin_two_out,
    output logic                       general_pin_two_oe,
    input  wire logic                  general_pin_three_in,
    output logic                       general_pin_three_out,
    output logic                       general_pin_three_oe
);

    rsc_state_t      state;
    rsc_state_t      next_state;
    logic            verbose;
    logic            group_event;
    logic            irq_armed;
    logic            irq_start;
    logic            ready_active;
    logic            irq_active;
    rsc_status_reg_t status_view;
    rsc_blkerr_reg_t blkerr_view;

    function automatic rsc_err_lvl_t err_level(input logic [2:0] cnt);
        if (cnt == '0) begin
            return RSC_LVL_NONE;
        end else if (cnt <= RSC_ERR_LOW_MAX) begin
            return RSC_LVL_LOW;
        end else if (cnt <= RSC_ERR_MID_MAX) begin
            return RSC_LVL_MID;
        end
        return RSC_LVL_BAD;
    endfunction

    // Returns {oe, out} for one general pin
    function automatic logic [1:0] pin_drive(input rsc_pin_fn_t fn,
                                             input logic special_on,
                                             input logic special_level);
        unique case (fn)
            RSC_PIN_HIZ:     return 2'h0;
            RSC_PIN_SPECIAL: return {special_on, special_level};
            RSC_PIN_LOW:     return 2'h2;
            RSC_PIN_HIGH:    return 2'h3;
        endcase
    endfunction

    assign verbose = state.ctrl.rds_verbose_select;
    // Standard mode counts valid groups, verbose mode any group while in sync
    assign group_event = state.cfg.rds_enable && rds_in.group_strobe &&
                         (verbose ? rds_in.sync : rds_in.group_valid);
    assign irq_armed = state.cfg.rds_irq_enable &&
                       (state.cfg.pin_two_function == RSC_PIN_SPECIAL);
    assign irq_start = group_event && irq_armed;

    rsc_hold_timer #(
        .CYCLES (READY_HOLD_CYCLES)
    ) u_ready_timer (
        .clock  (clock),
        .nrst   (nrst),
        .start  (group_event),
        .active (ready_active)
    );

    rsc_hold_timer #(
        .CYCLES (IRQ_LOW_CYCLES)
    ) u_irq_timer (
        .clock  (clock),
        .nrst   (nrst),
        .start  (irq_start),
        .active (irq_active)
    );

    always_comb begin
        status_view                     = '0;
        status_view.rds_group_ready     = ready_active;
        status_view.pilot_lock_flag     = state.pilot_lock;
        status_view.bus_mode_strap      = state.strap;
        status_view.pin_level           = {general_pin_three_in, general_pin_two_in,
                                           general_pin_one_in};
        blkerr_view                     = '0;
        // Sync and error levels only visible in verbose mode
        if (verbose) begin
            status_view.rds_sync_flag       = state.sync_flag;
            status_view.block_a_error_level = state.levels[0];
            blkerr_view.block_b_error_level = state.levels[1];
            blkerr_view.block_c_error_level = state.levels[2];
            blkerr_view.block_d_error_level = state.levels[3];
        end
    end

    always_comb begin
        next_state = state;

        // Register writes; reserved bits are kept at zero
        if (write_strobe) begin
            unique case (address)
                RSC_REG_CTRL: begin
                    next_state.ctrl      = rsc_ctrl_reg_t'(write_data);
                    next_state.ctrl.rsv0 = '0;
                    next_state.ctrl.rsv1 = '0;
                end
                RSC_REG_CFG: begin
                    next_state.cfg      = rsc_cfg_reg_t'(write_data);
                    next_state.cfg.rsv1 = '0;
                    next_state.cfg.rsv2 = '0;
                end
                RSC_REG_AUDIO: begin
                    next_state.audio      = rsc_audio_reg_t'(write_data);
                    next_state.audio.rsv0 = '0;
                    next_state.audio.rsv1 = '0;
                end
                default: begin
                end
            endcase
        end

        // Read data stands only in the cycle after the strobe
        next_state.rdata = '0;
        if (read_strobe) begin
            unique case (address)
                RSC_REG_CTRL:   next_state.rdata = RSC_DATA_W'(state.ctrl);
                RSC_REG_CFG:    next_state.rdata = RSC_DATA_W'(state.cfg);
                RSC_REG_AUDIO:  next_state.rdata = RSC_DATA_W'(state.audio);
                RSC_REG_STATUS: next_state.rdata = RSC_DATA_W'(status_view);
                RSC_REG_BLKERR: next_state.rdata = RSC_DATA_W'(blkerr_view);
                default:        next_state.rdata = '0;
            endcase
        end

        next_state.sync_flag = state.cfg.rds_enable && verbose && rds_in.sync;

        if (group_event && verbose) begin
            for (int i = 0; i < RSC_BLOCKS; i++) begin
                next_state.levels[i] = err_level(rds_in.err_cnt[i]);
            end
        end

        // Forced mono reports as mono
        next_state.pilot_lock = pilot_detect &&
                                !state.ctrl.force_single_channel;

        // Strap levels caught in the first cycle after reset release
        next_state.strap_pending = 1'b0;
        if (state.strap_pending) begin
            next_state.strap = {general_pin_three_in, general_pin_one_in};
        end

        // Pin drivers run independently of the RDS and power enables
        {next_state.pin_oe[0], next_state.pin_out[0]} =
            pin_drive(state.cfg.pin_one_function, 1'b0, 1'b0);
        {next_state.pin_oe[1], next_state.pin_out[1]} =
            pin_drive(state.cfg.pin_two_function, 1'b1,
                      !(state.cfg.rds_irq_enable && irq_active));
        {next_state.pin_oe[2], next_state.pin_out[2]} =
            pin_drive(state.cfg.pin_three_function, 1'b1, state.pilot_lock);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state               <= '0;
            state.strap_pending <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign read_data             = state.rdata;
    assign rds_enable            = state.cfg.rds_enable;
    assign rds_group_ready       = ready_active;
    assign bus_mode_strap        = state.strap;
    assign general_pin_one_out   = state.pin_out[0];
    assign general_pin_one_oe    = state.pin_oe[0];
    assign general_pin_two_out   = state.pin_out[1];
    assign general_pin_two_oe    = state.pin_oe[1];
    assign general_pin_three_out = state.pin_out[2];
    assign general_pin_three_oe  = state.pin_oe[2];

    always_comb begin
        audio_ctl                      = '0;
        audio_ctl.gain_loop_off        = state.cfg.gain_loop_off;
        audio_ctl.force_single_channel = state.ctrl.force_single_channel;
        audio_ctl.blend_range_adjust   = state.cfg.blend_range_adjust;
        audio_ctl.emphasis_time_select = state.cfg.emphasis_time_select;
        audio_ctl.audio_silence        = state.ctrl.audio_silence;
        audio_ctl.volume               = state.audio.volume;
        audio_ctl.volume_range_extend  = state.audio.volume_range_extend;
        audio_ctl.soft_silence_rate    = state.audio.soft_silence_rate;
        audio_ctl.soft_silence_depth   = state.audio.soft_silence_depth;
        audio_ctl.soft_silence_off     = state.ctrl.soft_silence_off;
    end

    // Length of the current ready hold, for checking only
    logic [RSC_TMR_W-1:0] hold_len;
    rsc_status_reg_t      status_seen;

    assign status_seen = rsc_status_reg_t'(read_data);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            hold_len <= '0;
        end else if (ready_active) begin
            hold_len <= hold_len + 1'b1;
        end else begin
            hold_len <= '0;
        end
    end

    a_ready_on_group: assert property (
        @(posedge clock) disable iff (!nrst)
        (state.cfg.rds_enable && !verbose && rds_in.group_strobe && rds_in.group_valid)
        |=> rds_group_ready
    ) else $error("ready not raised after valid group");

    a_ready_min_hold: assert property (
        @(posedge clock) disable iff (!nrst)
        $fell(ready_active) |-> (hold_len >= READY_HOLD_CYCLES)
    ) else $error("ready hold shorter than minimum");

    a_std_invalid_quiet: assert property (
        @(posedge clock) disable iff (!nrst)
        (!verbose && rds_in.group_strobe && !rds_in.group_valid && !ready_active)
        |=> !ready_active
    ) else $error("invalid group raised ready");

    a_disabled_no_ready: assert property (
        @(posedge clock) disable iff (!nrst)
        (!state.cfg.rds_enable && !ready_active) |=> !ready_active
    ) else $error("ready raised while reporting disabled");

    a_pin_two_pulse: assert property (
        @(posedge clock) disable iff (!nrst)
        (group_event && irq_armed && !write_strobe)
        |-> ##2 (general_pin_two_oe && !general_pin_two_out) [*8]
    ) else $error("pin two did not pulse low after group");

    a_pin_two_rest: assert property (
        @(posedge clock) disable iff (!nrst)
        ($past(state.cfg.pin_two_function) == RSC_PIN_SPECIAL && !$past(irq_active))
        |-> (general_pin_two_oe && general_pin_two_out)
    ) else $error("pin two low outside pulse");

    a_std_zero_reads: assert property (
        @(posedge clock) disable iff (!nrst)
        (read_strobe && !verbose && address == RSC_REG_BLKERR) |=> (read_data == '0)
    ) else $error("error levels nonzero in standard mode");

    a_sync_follow: assert property (
        @(posedge clock) disable iff (!nrst)
        (verbose && state.cfg.rds_enable && rds_in.sync && !write_strobe)
        |=> state.sync_flag ##1 (state.sync_flag == $past(rds_in.sync))
    ) else $error("sync flag does not follow decoder");

    a_mono_forced: assert property (
        @(posedge clock) disable iff (!nrst)
        state.ctrl.force_single_channel |=> !state.pilot_lock
    ) else $error("stereo reported while mono forced");

    a_strap_capture: assert property (
        @(posedge clock) disable iff (!nrst)
        (nrst && state.strap_pending)
        |=> (bus_mode_strap == {$past(general_pin_three_in), $past(general_pin_one_in)})
    ) else $error("bus mode strap not captured");

    a_level_uncorrectable: assert property (
        @(posedge clock) disable iff (!nrst)
        (group_event && verbose && rds_in.err_cnt[3] > RSC_ERR_MID_MAX)
        |=> (state.levels[3] == RSC_LVL_BAD)
    ) else $error("six or more errors not marked uncorrectable");

    a_std_status_zero: assert property (
        @(posedge clock) disable iff (!nrst)
        (read_strobe && !verbose && address == RSC_REG_STATUS)
        |=> (status_seen.rds_sync_flag == 1'b0 && status_seen.block_a_error_level == '0)
    ) else $error("sync or level A nonzero in standard mode");

    a_unsynced_quiet: assert property (
        @(posedge clock) disable iff (!nrst)
        (verbose && rds_in.group_strobe && !rds_in.sync && !ready_active)
        |=> !ready_active
    ) else $error("ready raised by unsynchronised group");

    a_irq_off_high: assert property (
        @(posedge clock) disable iff (!nrst)
        (state.cfg.pin_two_function == RSC_PIN_SPECIAL && !state.cfg.rds_irq_enable)
        |=> (general_pin_two_oe && general_pin_two_out)
    ) else $error("pin two low with interrupt disabled");

    a_pin_one_drive: assert property (
        @(posedge clock) disable iff (!nrst)
        (state.cfg.pin_one_function == RSC_PIN_LOW)
        |=> (general_pin_one_oe && !general_pin_one_out)
    ) else $error("pin one not driven low");

    a_pin_three_stereo: assert property (
        @(posedge clock) disable iff (!nrst)
        (state.cfg.pin_three_function == RSC_PIN_SPECIAL)
        |=> (general_pin_three_oe && general_pin_three_out == $past(state.pilot_lock))
    ) else $error("pin three does not show stereo status");

    a_std_sync_clear: assert property (
        @(posedge clock) disable iff (!nrst)
        !verbose |=> !state.sync_flag
    ) else $error("sync flag set in standard mode");

endmodule

/* test/rsc_ctl_model.sv */
// Controller side model: bus mode strap drivers and general pin wiring
`timescale 1ns/1ps
module rsc_ctl_model (
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic [1:0] strap,
    output logic [2:0]      pin_level
);
    // Pins one and three carry the strap levels, pin two has a pull-up
    assign pin_level[0] = pin_oe[0] ? pin_out[0] : strap[0];
    assign pin_level[1] = pin_oe[1] ? pin_out[1] : 1'b1;
    assign pin_level[2] = pin_oe[2] ? pin_out[2] : strap[1];
endmodule

/* test/rsc_rds_ctrl_test.sv */
// Self-checking bench of the RDS status and audio control block
`timescale 1ns/1ps
module rsc_rds_ctrl_test
    import rsc_pkg::*;
;
    localparam int HOLD = 20;
    localparam int LOW  = 10;
    logic                  clock = 1'b0;
    logic                  nrst = 1'b0;
    logic [RSC_ADDR_W-1:0] address = '0;
    logic [RSC_DATA_W-1:0] write_data = '0;
    logic                  write_strobe = 1'b0;
    logic                  read_strobe = 1'b0;
    logic [RSC_DATA_W-1:0] read_data;
    rsc_rds_in_t           rds_in = '0;
    logic                  pilot_detect = 1'b0;
    logic                  rds_enable;
    logic                  rds_group_ready;
    rsc_audio_ctl_t        audio_ctl;
    logic [1:0]            bus_mode_strap;
    logic [2:0]            pin_out;
    logic [2:0]            pin_oe;
    logic [2:0]            pin_level;
    logic [1:0]            strap = 2'h0;
    logic [15:0]           v;
    logic [15:0]           ctrl;
    logic [15:0]           cfg;
    logic [15:0]           aud;
    int                    seed = 90;
    int                    n_mismatch = 0;
    int                    tests_run = 0;

    always #10 clock = ~clock;

    rsc_rds_ctrl #(
        .READY_HOLD_CYCLES(RSC_TMR_W'(HOLD)),
        .IRQ_LOW_CYCLES   (RSC_TMR_W'(LOW))
    ) i_dut (
        .clock(clock), .nrst(nrst), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .rds_in(rds_in), .pilot_detect(pilot_detect), .rds_enable(rds_enable),
        .rds_group_ready(rds_group_ready), .audio_ctl(audio_ctl),
        .bus_mode_strap(bus_mode_strap),
        .general_pin_one_in(pin_level[0]), .general_pin_one_out(pin_out[0]),
        .general_pin_one_oe(pin_oe[0]), .general_pin_two_in(pin_level[1]),
        .general_pin_two_out(pin_out[1]), .general_pin_two_oe(pin_oe[1]),
        .general_pin_three_in(pin_level[2]), .general_pin_three_out(pin_out[2]),
        .general_pin_three_oe(pin_oe[2])
    );

    rsc_ctl_model i_model (.pin_out(pin_out), .pin_oe(pin_oe), .strap(strap),
                           .pin_level(pin_level));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        d = read_data;
    endtask

    // One group, then count ready cycles and low cycles on pin two
    task automatic group(input logic valid, input logic [11:0] errs, input int er, input int el);
        int nr;
        int nl;
        nr = 0;
        nl = 0;
        @(posedge clock);
        rds_in.group_strobe <= 1'b1;
        rds_in.group_valid <= valid;
        rds_in.err_cnt <= errs;
        @(posedge clock);
        rds_in.group_strobe <= 1'b0;
        repeat (40) begin
            #1;
            if (rds_group_ready === 1'b1) nr++;
            if (pin_level[1] === 1'b0) nl++;
            @(posedge clock);
        end
        check("ready_cycles", 16'(nr), 16'(er));
        check("pin_two_low", 16'(nl), 16'(el));
    endtask

    function automatic logic [15:0] exp_audio(input logic [15:0] c, f, a);
        return {f[10], c[13], f[9:8], f[11], c[15], a[3:0], a[8], a[15:14], a[13:12], c[14]};
    endfunction

    initial begin
        #1_000_000;
        n_mismatch++;
        close_out();
    end

    initial begin
        strap = 2'($random(seed));
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        idle(3);
        check("strap", 16'(bus_mode_strap), 16'(strap));
        check("audio_rst", audio_ctl, 16'h0000);
        rd(RSC_REG_CTRL, v);
        check("ctrl_rst", v, 16'h0000);
        rd(4'h7, v);
        check("unmapped", v, 16'h0000);
        done("reset");
        repeat (6) begin
            ctrl = 16'($random(seed));
            cfg  = 16'($random(seed));
            aud  = 16'($random(seed));
            wr(RSC_REG_CTRL, ctrl);
            wr(RSC_REG_CFG, cfg);
            wr(RSC_REG_AUDIO, aud);
            check("audio_ctl", audio_ctl, exp_audio(ctrl, cfg, aud));
            rd(RSC_REG_CFG, v);
            check("cfg", v, cfg & 16'h9f3f);
            rd(RSC_REG_AUDIO, v);
            check("audio", v, aud & 16'hf10f);
            rd(RSC_REG_CTRL, v);
            check("ctrl", v, ctrl & 16'he040);
        end
        done("registers");
        wr(RSC_REG_CTRL, 16'h0000);
        @(posedge clock) pilot_detect <= 1'b1;
        wr(RSC_REG_CFG, 16'h000e);
        idle(3);
        rd(RSC_REG_STATUS, v);
        check("pins_drive", 16'(v[2:0]), 16'({strap[1], 2'b10}));
        check("pilot", 16'(v[8]), 16'h0001);
        wr(RSC_REG_CFG, 16'h0014);
        idle(3);
        check("pin3_stereo", 16'(pin_level[2]), 16'h0001);
        wr(RSC_REG_CTRL, 16'h2000);
        idle(3);
        check("pin3_mono", 16'(pin_level[2]), 16'h0000);
        done("pins");
        @(posedge clock) rds_in.sync <= 1'b1;
        wr(RSC_REG_CTRL, 16'h0000);
        wr(RSC_REG_CFG, 16'h8004);
        group(1'b1, 12'hfff, 0, 0);
        wr(RSC_REG_CFG, 16'h9004);
        check("rds_enable", 16'(rds_enable), 16'h0001);
        group(1'b1, 12'hfff, HOLD, LOW);
        group(1'b0, 12'hfff, 0, 0);
        rd(RSC_REG_STATUS, v);
        check("std_status", v & 16'h10c0, 16'h0000);
        rd(RSC_REG_BLKERR, v);
        check("std_blkerr", v, 16'h0000);
        done("standard");
        wr(RSC_REG_CTRL, 16'h0040);
        idle(2);
        rd(RSC_REG_STATUS, v);
        check("sync_on", 16'(v[12]), 16'h0001);
        group(1'b0, {3'h6, 3'h5, 3'h2, 3'h3}, HOLD, LOW);
        rd(RSC_REG_STATUS, v);
        check("level_a", v & 16'h00c0, 16'h0080);
        rd(RSC_REG_BLKERR, v);
        check("levels_bcd", v, 16'h6c00);
        @(posedge clock) rds_in.sync <= 1'b0;
        idle(2);
        rd(RSC_REG_STATUS, v);
        check("sync_off", 16'(v[12]), 16'h0000);
        group(1'b1, 12'h000, 0, 0);
        done("verbose");
        close_out();
    end
endmodule
